//--- design/icar_regs.sv
// Control and own-address register logic of the I2C/SMBus controller
module icar_regs (
    input  wire logic        clk,
    input  wire logic        reset,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [15:0] reg_rdata,
    // Engine events
    input  wire logic        packet_check_sent,
    input  wire logic        start_sent,
    input  wire logic        stop_sent,
    input  wire logic        master_receive,
    // Status flags from the engine
    input  wire logic        alert_flag,
    input  wire logic        timeout_flag,
    input  wire logic        packet_check_error_flag,
    input  wire logic        overrun_underrun_flag,
    input  wire logic        ack_failure_flag,
    input  wire logic        arbitration_lost_flag,
    input  wire logic        bus_error_flag,
    input  wire logic        start_sent_flag,
    input  wire logic        address_done_flag,
    input  wire logic        header10_sent_flag,
    input  wire logic        stop_received_flag,
    input  wire logic        byte_done_flag,
    input  wire logic        transmit_empty_flag,
    input  wire logic        receive_full_flag,
    // Controls toward the engine
    output logic             periph_enable,
    output logic             smbus_mode_select,
    output logic             ack_send_enable,
    output logic             ack_position_select,
    output logic             packet_check_send,
    output logic             engine_reset,
    output logic             clock_setting_valid,
    output logic [5:0]       bus_clock_mhz,
    output logic             error_irq,
    output logic             event_irq,
    output logic             dma_request,
    output logic             dma_last_transfer,
    output logic             own_address_length,
    output logic [9:0]       own_address_match,
    // SMBus alert pin, open drain
    input  wire logic        smb_alert_in,
    output logic             smb_alert_out,
    output logic             smb_alert_oe,
    output logic             smb_alert_level
);

    logic [15:0] control_one_r;
    logic [15:0] control_one_nxt;
    logic [15:0] control_two_r;
    logic [15:0] control_two_nxt;
    logic [15:0] own_address_one_r;
    logic [15:0] own_address_one_nxt;
    logic [15:0] reg_rdata_nxt;
    logic        alert_meta_r;
    logic        alert_sync_r;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction : hit

    // Register writes and hardware clears
    always_comb begin
        control_one_nxt     = control_one_r;
        control_two_nxt     = control_two_r;
        own_address_one_nxt = own_address_one_r;
        if (reg_write && hit(reg_addr, icar_pkg::ADDR_CONTROL_ONE)) begin
            control_one_nxt = reg_wdata & icar_pkg::C1_MASK;
        end
        if (reg_write && hit(reg_addr, icar_pkg::ADDR_CONTROL_TWO)) begin
            control_two_nxt = reg_wdata & icar_pkg::C2_MASK;
        end
        if (reg_write && hit(reg_addr, icar_pkg::ADDR_OWN_ADDRESS_ONE)) begin
            own_address_one_nxt = reg_wdata & icar_pkg::OA_MASK;
        end
        // Hardware clear of the packet check request wins over a write
        if (packet_check_sent || start_sent || stop_sent) begin
            control_one_nxt[icar_pkg::C1_PACKET_CHECK] = 1'b0;
        end
        // Alert bit survives disable on purpose; software owns it
        if (!control_one_nxt[icar_pkg::C1_PERIPH_ENABLE]) begin
            control_one_nxt[icar_pkg::C1_ACK_SEND]     = 1'b0;
            control_one_nxt[icar_pkg::C1_ACK_POSITION] = 1'b0;
            control_one_nxt[icar_pkg::C1_PACKET_CHECK] = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            control_one_r     <= icar_pkg::C1_RESET;
            control_two_r     <= icar_pkg::C2_RESET;
            own_address_one_r <= icar_pkg::OA_RESET;
        end else begin
            control_one_r     <= control_one_nxt;
            control_two_r     <= control_two_nxt;
            own_address_one_r <= own_address_one_nxt;
        end
    end

    // Read data, one cycle after the strobe; unmapped reads give zero
    always_comb begin
        reg_rdata_nxt = 16'h0000;
        if (reg_read) begin
            case (1'b1)
                hit(reg_addr, icar_pkg::ADDR_CONTROL_ONE):
                    reg_rdata_nxt = control_one_r;
                hit(reg_addr, icar_pkg::ADDR_CONTROL_TWO):
                    reg_rdata_nxt = control_two_r;
                hit(reg_addr, icar_pkg::ADDR_OWN_ADDRESS_ONE):
                    reg_rdata_nxt = own_address_one_r;
                default:
                    reg_rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= reg_rdata_nxt;
        end
    end

    // Alert pin level seen from outside, two-flop synchronised
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            alert_meta_r <= 1'b1;
            alert_sync_r <= 1'b1;
        end else begin
            alert_meta_r <= smb_alert_in;
            alert_sync_r <= alert_meta_r;
        end
    end

    assign smb_alert_level = alert_sync_r;

    // Controls toward the engine
    assign periph_enable       = control_one_r[icar_pkg::C1_PERIPH_ENABLE];
    assign smbus_mode_select   = control_one_r[icar_pkg::C1_SMBUS_MODE];
    assign ack_send_enable     = control_one_r[icar_pkg::C1_ACK_SEND];
    assign ack_position_select = control_one_r[icar_pkg::C1_ACK_POSITION];
    assign packet_check_send   = control_one_r[icar_pkg::C1_PACKET_CHECK];
    // Engine stays reset while soft reset is set; caller must idle bus first
    assign engine_reset        = control_one_r[icar_pkg::C1_SOFT_RESET];

    // Open drain: drive low only, release means high by pull-up
    assign smb_alert_out = 1'b0;
    assign smb_alert_oe  = control_one_r[icar_pkg::C1_ALERT_DRIVE];

    assign bus_clock_mhz =
        control_two_r[icar_pkg::C2_CLK_MSB:icar_pkg::C2_CLK_LSB];
    assign clock_setting_valid =
        (bus_clock_mhz >= icar_pkg::CLK_MHZ_MIN) &&
        (bus_clock_mhz <= icar_pkg::CLK_MHZ_MAX);

    assign error_irq = control_two_r[icar_pkg::C2_ERROR_IRQ] &&
        (alert_flag || timeout_flag || packet_check_error_flag ||
         overrun_underrun_flag || ack_failure_flag ||
         arbitration_lost_flag || bus_error_flag);

    assign event_irq = control_two_r[icar_pkg::C2_EVENT_IRQ] &&
        (start_sent_flag || address_done_flag || header10_sent_flag ||
         stop_received_flag || byte_done_flag ||
         (control_two_r[icar_pkg::C2_BUFFER_IRQ] &&
          (transmit_empty_flag || receive_full_flag)));

    assign dma_request = control_two_r[icar_pkg::C2_DMA_ENABLE] &&
        (transmit_empty_flag || receive_full_flag);

    assign dma_last_transfer = control_two_r[icar_pkg::C2_LAST_TRANSFER] &&
        master_receive;

    // Address used for matching; unused bits forced to zero in 7-bit mode
    assign own_address_length = own_address_one_r[icar_pkg::OA_LENGTH];
    assign own_address_match = own_address_length ?
        own_address_one_r[9:0] :
        {2'b00, own_address_one_r[7:1], 1'b0};

endmodule : icar_regs

//--- include/icar_pkg.sv
// Register map, field positions and reset values of the control/address block
package icar_pkg;

    localparam logic [7:0] ADDR_CONTROL_ONE     = 8'h00;
    localparam logic [7:0] ADDR_CONTROL_TWO     = 8'h04;
    localparam logic [7:0] ADDR_OWN_ADDRESS_ONE = 8'h08;

    // Control one fields
    localparam int C1_PERIPH_ENABLE   = 0;
    localparam int C1_SMBUS_MODE      = 1;
    localparam int C1_ACK_SEND        = 10;
    localparam int C1_ACK_POSITION    = 11;
    localparam int C1_PACKET_CHECK    = 12;
    localparam int C1_ALERT_DRIVE     = 13;
    localparam int C1_SOFT_RESET      = 15;
    localparam logic [15:0] C1_MASK   = 16'hBC03;
    localparam logic [15:0] C1_RESET  = 16'h0000;

    // Control two fields
    localparam int C2_CLK_LSB         = 0;
    localparam int C2_CLK_MSB         = 5;
    localparam int C2_ERROR_IRQ       = 8;
    localparam int C2_EVENT_IRQ       = 9;
    localparam int C2_BUFFER_IRQ      = 10;
    localparam int C2_DMA_ENABLE      = 11;
    localparam int C2_LAST_TRANSFER   = 12;
    localparam logic [15:0] C2_MASK   = 16'h1F3F;
    localparam logic [15:0] C2_RESET  = 16'h0000;

    // Clock setting limits in MHz
    localparam logic [5:0] CLK_MHZ_MIN = 6'h02;
    localparam logic [5:0] CLK_MHZ_MAX = 6'h24;

    // Own address one fields
    localparam int OA_LENGTH          = 15;
    localparam logic [15:0] OA_MASK   = 16'h83FF;
    localparam logic [15:0] OA_RESET  = 16'h0000;

endpackage : icar_pkg

//--- verification/icar_engine_model.sv
// Engine-side model: status flags, event pulses and the alert line
module icar_engine_model (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [13:0] cmd_flags,
    input  wire logic [2:0]  cmd_pulse,
    input  wire logic        alert_oe,
    input  wire logic        alert_out,
    output logic      [13:0] flags,
    output logic      [2:0]  pulses,
    output logic             alert_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // Flags and pulses follow the bench commands one clock later
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flags  <= '0;
            pulses <= '0;
        end else begin
            flags  <= cmd_flags;
            pulses <= cmd_pulse;
        end
    end
    // Open drain with pull-up: released line reads high
    assign alert_pin = alert_oe ? alert_out : 1'b1;
endmodule : icar_engine_model

//--- verification/icar_regs_sva.sv
// Checker of the control/address register block
module icar_regs_chk (
    input wire logic clk, reset, reg_write, start_sent, stop_sent,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic packet_check_sent, periph_enable, ack_send_enable,
    input wire logic ack_position_select, packet_check_send, engine_reset,
    input wire logic smb_alert_oe, clock_setting_valid, dma_request,
    input wire logic dma_last_transfer, transmit_empty_flag,
    input wire logic receive_full_flag, master_receive, own_address_length,
    input wire logic [5:0] bus_clock_mhz,
    input wire logic [9:0] own_address_match
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire c1_wr = reg_write && reg_addr == 8'h00;
    ack_clear_a: assert property (
        !periph_enable |-> !ack_send_enable) else $error("ack kept");
    pos_clear_a: assert property (
        !periph_enable |-> !ack_position_select) else $error("pos kept");
    pec_clear_a: assert property (
        start_sent || stop_sent || packet_check_sent |=> !packet_check_send)
        else $error("packet check not cleared");
    alert_drive_a: assert property (
        c1_wr |=> smb_alert_oe == $past(reg_wdata[13])) else $error("alert");
    soft_reset_a: assert property (
        c1_wr |=> engine_reset == $past(reg_wdata[15])) else $error("reset");
    clk_valid_a: assert property (
        clock_setting_valid == (bus_clock_mhz >= 6'h02
        && bus_clock_mhz <= 6'h24)) else $error("clock valid");
    dma_req_a: assert property (
        dma_request |-> transmit_empty_flag || receive_full_flag)
        else $error("dma without flag");
    last_xfer_a: assert property (
        dma_last_transfer |-> master_receive) else $error("last transfer");
    addr_seven_a: assert property (
        !own_address_length |-> own_address_match[9:8] == 2'h0
        && !own_address_match[0]) else $error("7-bit match");
    cover property (dma_request);
    cover property (own_address_length);
    cover property (start_sent && packet_check_send);
endmodule : icar_regs_chk
bind icar_regs icar_regs_chk icar_regs_chk_i (.*);

//--- verification/tb.sv
// Self-checking bench of the control/address register block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, reset = 1, reg_write = 0, reg_read = 0, mrx = 0;
    logic [7:0] reg_addr = '0;
    logic [15:0] reg_wdata = '0, reg_rdata, en;
    logic [13:0] cmd_flags = '0, fl;
    logic [2:0] cmd_pulse = '0, pl;
    logic ack, erst, cval, eirq, virq, dreq, dlast, olen, a_out, a_oe, a_lvl;
    logic pin, pe, smb, apos, pecs;
    logic [5:0] bclk;
    logic [15:0] en_list [4] = '{16'h0100, 16'h0200, 16'h0600, 16'h1800};
    logic [9:0] omatch;
    int miscompares = 0, check_count = 0, cyc = 0;
    logic [15:0] rows [6][3] = '{'{16'h0000, 16'hFFFF, 16'hBC03},
        '{16'h0000, 16'h3C02, 16'h2002}, '{16'h0004, 16'hFFFF, 16'h1F3F},
        '{16'h0008, 16'hFFFF, 16'h83FF}, '{16'h000C, 16'hFFFF, 16'h0000},
        '{16'h0004, 16'h0A02, 16'h0A02}};
    always #50 clk = ~clk;
    icar_engine_model icar_engine_model_i (.clk(clk), .reset(reset),
        .cmd_flags(cmd_flags), .cmd_pulse(cmd_pulse), .alert_oe(a_oe),
        .alert_out(a_out), .flags(fl), .pulses(pl), .alert_pin(pin));
    icar_regs icar_regs_i (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .packet_check_sent(pl[0]), .start_sent(pl[1]),
        .stop_sent(pl[2]), .master_receive(mrx), .alert_flag(fl[0]),
        .timeout_flag(fl[1]), .packet_check_error_flag(fl[2]),
        .overrun_underrun_flag(fl[3]), .ack_failure_flag(fl[4]),
        .arbitration_lost_flag(fl[5]), .bus_error_flag(fl[6]),
        .start_sent_flag(fl[7]), .address_done_flag(fl[8]),
        .header10_sent_flag(fl[9]), .stop_received_flag(fl[10]),
        .byte_done_flag(fl[11]), .transmit_empty_flag(fl[12]),
        .receive_full_flag(fl[13]), .periph_enable(pe),
        .smbus_mode_select(smb), .ack_send_enable(ack),
        .ack_position_select(apos), .packet_check_send(pecs),
        .engine_reset(erst), .clock_setting_valid(cval), .bus_clock_mhz(bclk),
        .error_irq(eirq), .event_irq(virq), .dma_request(dreq),
        .dma_last_transfer(dlast), .own_address_length(olen),
        .own_address_match(omatch), .smb_alert_in(pin), .smb_alert_out(a_out),
        .smb_alert_oe(a_oe), .smb_alert_level(a_lvl));
    task automatic chk(input string n, input logic [15:0] e, g);
        check_count++;
        if (e !== g) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_write <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_read <= 1'b1; reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk("rdata", e, reg_rdata);
    endtask : rd
    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 12; i += 4) rd(8'(i), 16'h0000);
        for (int r = 0; r < 6; r++) begin
            wr(rows[r][0][7:0], rows[r][1]);
            rd(rows[r][0][7:0], rows[r][2]);
        end
        chk("ack", 16'h0000, ack);
        for (int v = 0; v < 64; v++) begin
            wr(8'h04, 16'(v));
            chk("clkok", 16'(v >= 2 && v <= 36), cval);
            chk("clkmhz", 16'(v), 16'(bclk));
        end
        wr(8'h00, 16'h1C03);
        chk("en", 16'h0001, pe);
        chk("smb", 16'h0001, smb);
        chk("ack1", 16'h0001, ack);
        chk("pos", 16'h0001, apos);
        chk("pecs", 16'h0001, pecs);
        mrx <= 1'b1;
        foreach (en_list[j]) begin
            en = en_list[j];
            wr(8'h04, en);
            for (int k = 0; k < 14; k++) begin
                @(posedge clk) cmd_flags <= 14'(1 << k);
                @(posedge clk) #1;
                chk("err", 16'(en[8] && k < 7), eirq);
                chk("evt", 16'(en[9] && (k < 12 ? k > 6 : en[10])), virq);
                chk("dma", 16'(en[11] && k > 11), dreq);
                chk("last", 16'(en[12]), dlast);
            end
        end
        mrx <= 1'b0;
        @(posedge clk) #1;
        chk("last0", 16'h0000, dlast);
        for (int p = 0; p < 3; p++) begin
            wr(8'h00, 16'h1001);
            @(posedge clk) cmd_pulse <= 3'(1 << p);
            @(posedge clk) cmd_pulse <= 3'h0;
            rd(8'h00, 16'h0001);
        end
        wr(8'h00, 16'hA000);
        repeat (3) @(posedge clk);
        #1 chk("pin", 16'h0000, a_lvl);
        chk("aout", 16'h0000, a_out);
        chk("srst", 16'h0001, erst);
        wr(8'h08, 16'h03FF);
        chk("match7", 16'h00FE, omatch);
        wr(8'h08, 16'h83FF);
        chk("match10", 16'h03FF, omatch);
        @(posedge clk) reset <= 1'b1;
        @(posedge clk) reset <= 1'b0;
        rd(8'h08, 16'h0000);
        report_and_stop();
    end
endmodule : tb
